// ===== hdl/ifc_regs.svh
// register offsets, field positions, reset values and vector addresses
`ifndef IFC_REGS_SVH
`define IFC_REGS_SVH

// zero-page special function window
`define IFC_SFR_LO     16'h00c0
`define IFC_SFR_HI     16'h00ff
`define IFC_PAGE_ZERO  8'h00

// register offsets inside page zero
`define IFC_OFF_ENABLE 8'hc2
`define IFC_OFF_STATUS 8'hc3

// reset values
`define IFC_ENABLE_RST 7'h00
`define IFC_STATUS_RST 8'h00
`define IFC_RDATA_RST  8'h00

// field positions, shared by enable and status; watchdog bit seven is in status only
`define IFC_BIT_RTC    0
`define IFC_BIT_SUPPLY 1
`define IFC_BIT_PORT   2
`define IFC_BIT_TM0    3
`define IFC_BIT_DIV    4
`define IFC_BIT_TM1    5
`define IFC_BIT_TM2    6
`define IFC_BIT_WDT    7
`define IFC_SRC_NUM    7

// service routine vector bytes at the top of memory
`define IFC_VEC_LO     16'hfffe
`define IFC_VEC_HI     16'hffff
`define IFC_VEC_IDLE   16'h0000

// port width
`define IFC_PORT_W     8

`endif

// ===== hdl/ifc_pkg.sv
// types shared by the interrupt flag controller
package ifc_pkg;

  // vector fetch sequencer states
  typedef enum {
    VEC_IDLE,
    VEC_LO,
    VEC_HI
  } ifc_vec_state_e;

  typedef logic [7:0]  ifc_byte_t;
  typedef logic [15:0] ifc_addr_t;

endpackage

// ===== hdl/ifc_event_detect.sv
// edge detection of port and supply inputs, packed into one event vector
`timescale 1ns/1ns
`include "ifc_regs.svh"

module ifc_event_detect (
  // clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_resetn,
  // pulse sources
  input  wire logic                    i_tm0,
  input  wire logic                    i_tm1,
  input  wire logic                    i_tm2,
  input  wire logic                    i_div,
  input  wire logic                    i_rtc,
  input  wire logic                    i_wdt,
  // level sources
  input  wire logic [`IFC_PORT_W-1:0]  i_port_pin,
  input  wire logic [`IFC_PORT_W-1:0]  i_port_in_mode,
  input  wire logic                    i_supply,
  // packed events
  output ifc_pkg::ifc_byte_t           o_event
);

  // =====================================================
  // history of the sampled levels
  // =====================================================
  logic [`IFC_PORT_W-1:0] port_prev_ff;
  logic                   supply_prev_ff;
  logic                   primed_ff;
  logic [`IFC_PORT_W-1:0] port_fall;
  logic                   port_falling_edge_event;
  logic                   secondary_supply_edge_event;

  // primed blocks a false edge on the first sample after reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      primed_ff <= 1'b0;
    end else begin
      primed_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      port_prev_ff   <= '0;
      supply_prev_ff <= 1'b0;
    end else begin
      port_prev_ff   <= i_port_pin;
      supply_prev_ff <= i_supply;
    end
  end

  // =====================================================
  // edge decode
  // =====================================================
  // output pins never raise the port event
  for (genvar g = 0; g < `IFC_PORT_W; g++) begin : g_fall
    assign port_fall[g] = primed_ff & i_port_in_mode[g]
                          & port_prev_ff[g] & ~i_port_pin[g];
  end

  assign port_falling_edge_event     = |port_fall;
  // both directions of the supply status count
  assign secondary_supply_edge_event = primed_ff & (supply_prev_ff ^ i_supply);

  // packed in status bit order
  assign o_event = {i_wdt, i_tm2, i_tm1, i_div, i_tm0,
                    port_falling_edge_event, secondary_supply_edge_event,
                    i_rtc};

  // =====================================================
  // checks
  // =====================================================
  AST_PORT_FALL: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    ($past(primed_ff) && |($past(i_port_pin) & ~i_port_pin & i_port_in_mode))
    |-> o_event[`IFC_BIT_PORT])
    else $error("port falling edge missed");

  AST_SUPPLY_EDGE: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (primed_ff && $changed(i_supply)) |-> o_event[`IFC_BIT_SUPPLY])
    else $error("supply edge missed");

endmodule // ifc_event_detect

// ===== hdl/ifc_top.sv
// interrupt flag controller: sfr registers, cpu request and vector fetch
`timescale 1ns/1ns
`include "ifc_regs.svh"

// =====================================================
// Notes on behaviour
// - registers answer only inside zero-page sfr window
// - taken request fetches vector bytes fffe, ffff
// - request when latched flag meets its enable
// - taken request blocks until cli or enable write
// - sei blocks pending and new requests
// - enable bit one permits, zero blocks; resets zero
// - falling edge on input port pin sets flag
// - each timer underflow sets its own flag
// - divider tick sets divider flag
// - both supply status edges set supply flag
// - half second rtc tick sets rtc flag
// - enable layout bits six to zero, bit seven unused
// - status read returns flags, watchdog in bit seven
// - writing one to clear bit resets flag
// - status and clear share one address

module ifc_top (
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESETN,
  // sfr access from the cpu core
  input  wire logic [15:0] I_SFR_ADDR,
  input  wire logic        I_SFR_WR,
  input  wire logic        I_SFR_RD,
  input  wire logic [7:0]  I_SFR_WDATA,
  output logic      [7:0]  O_SFR_RDATA,
  output logic             O_SFR_RVALID,
  // peripheral event pulses
  input  wire logic        I_TIMER_ZERO_UNDERFLOW,
  input  wire logic        I_TIMER_ONE_UNDERFLOW,
  input  wire logic        I_TIMER_TWO_UNDERFLOW,
  input  wire logic        I_DIV_TICK,
  input  wire logic        I_RTC_HALF_SEC_TICK,
  input  wire logic        I_WDT_EVENT,
  // level sources
  input  wire logic [7:0]  I_PORT_PIN,
  input  wire logic [7:0]  I_PORT_INPUT_MODE,
  input  wire logic        I_SECONDARY_SUPPLY_STATUS,
  // cpu core handshake
  input  wire logic        I_CPU_IRQ_TAKEN,
  input  wire logic        I_CPU_CLI,
  input  wire logic        I_CPU_SEI,
  output logic             O_IRQ_REQ,
  output logic             O_IRQ_DISABLED,
  output logic      [15:0] O_VEC_ADDR,
  output logic             O_VEC_FETCH
);

  // =====================================================
  // decode helpers
  // =====================================================
  // whole sfr window, shared by read and write paths
  function automatic logic in_window(input ifc_pkg::ifc_addr_t a);
    return (a >= `IFC_SFR_LO) && (a <= `IFC_SFR_HI);
  endfunction

  // one register inside page zero
  function automatic logic sfr_hit(input ifc_pkg::ifc_addr_t a,
                                   input ifc_pkg::ifc_byte_t off);
    return in_window(a) && (a == {`IFC_PAGE_ZERO, off});
  endfunction

  // =====================================================
  // declarations
  // =====================================================
  logic [`IFC_SRC_NUM-1:0]  enable_ff;
  ifc_pkg::ifc_byte_t       status_ff;
  ifc_pkg::ifc_byte_t       nxt_status;
  ifc_pkg::ifc_byte_t       evt_vec;
  ifc_pkg::ifc_byte_t       clr_mask;
  ifc_pkg::ifc_byte_t       nxt_rdata;
  logic                     nxt_rvalid;
  logic                     wr_enable;
  logic                     wr_clear;
  logic                     rd_enable;
  logic                     rd_status;
  logic                     inhibit_ff;
  logic                     disable_ff;
  logic                     pending;
  logic                     nxt_irq;
  ifc_pkg::ifc_vec_state_e  vec_state_ff;
  ifc_pkg::ifc_vec_state_e  nxt_vec_state;

  // =====================================================
  // event sources
  // =====================================================
  ifc_event_detect u_detect (
    .i_clk_sys      (I_CLK_SYS),
    .i_resetn       (I_RESETN),
    .i_tm0          (I_TIMER_ZERO_UNDERFLOW),
    .i_tm1          (I_TIMER_ONE_UNDERFLOW),
    .i_tm2          (I_TIMER_TWO_UNDERFLOW),
    .i_div          (I_DIV_TICK),
    .i_rtc          (I_RTC_HALF_SEC_TICK),
    .i_wdt          (I_WDT_EVENT),
    .i_port_pin     (I_PORT_PIN),
    .i_port_in_mode (I_PORT_INPUT_MODE),
    .i_supply       (I_SECONDARY_SUPPLY_STATUS),
    .o_event        (evt_vec)
  );

  // =====================================================
  // register access decode
  // =====================================================
  // other sfr addresses belong to other blocks; no answer here
  assign wr_enable = I_SFR_WR && sfr_hit(I_SFR_ADDR, `IFC_OFF_ENABLE);
  assign wr_clear  = I_SFR_WR && sfr_hit(I_SFR_ADDR, `IFC_OFF_STATUS);
  assign rd_enable = I_SFR_RD && sfr_hit(I_SFR_ADDR, `IFC_OFF_ENABLE);
  assign rd_status = I_SFR_RD && sfr_hit(I_SFR_ADDR, `IFC_OFF_STATUS);

  // =====================================================
  // enable register
  // =====================================================
  // bit seven has no storage, writes to it are dropped
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      enable_ff <= `IFC_ENABLE_RST;
    end else if (wr_enable) begin
      enable_ff <= I_SFR_WDATA[`IFC_SRC_NUM-1:0];
    end
  end

  // =====================================================
  // status flags
  // =====================================================
  // writes only clear; the event term is ored last so a set wins
  always_comb begin
    clr_mask   = wr_clear ? I_SFR_WDATA : `IFC_STATUS_RST;
    nxt_status = (status_ff & ~clr_mask) | evt_vec;
  end

  // flags latch whatever the enables say, masking is downstream
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      status_ff <= `IFC_STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // =====================================================
  // read path
  // =====================================================
  // one cycle read latency, data held until the next read
  always_comb begin
    nxt_rdata  = O_SFR_RDATA;
    nxt_rvalid = 1'b0;
    if (rd_enable) begin
      nxt_rdata  = {1'b0, enable_ff};
      nxt_rvalid = 1'b1;
    end else if (rd_status) begin
      nxt_rdata  = status_ff;
      nxt_rvalid = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SFR_RDATA  <= `IFC_RDATA_RST;
      O_SFR_RVALID <= 1'b0;
    end else begin
      O_SFR_RDATA  <= nxt_rdata;
      O_SFR_RVALID <= nxt_rvalid;
    end
  end

  // =====================================================
  // request gating
  // =====================================================
  // watchdog bit has no enable, so it never requests
  assign pending = |(status_ff[`IFC_SRC_NUM-1:0] & enable_ff);

  // inhibit set by a taken request; cli or enable store lifts it
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      inhibit_ff <= 1'b0;
    end else if (I_CPU_CLI || wr_enable) begin
      inhibit_ff <= 1'b0;
    end else if (I_CPU_IRQ_TAKEN) begin
      inhibit_ff <= 1'b1;
    end
  end

  // disable mirrors the cpu interrupt-disable flag
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      disable_ff <= 1'b0;
    end else if (I_CPU_SEI) begin
      disable_ff <= 1'b1;
    end else if (I_CPU_CLI) begin
      disable_ff <= 1'b0;
    end
  end

  // taken and sei act in their own cycle to avoid a stray repeat
  assign nxt_irq = pending && !inhibit_ff && !disable_ff
                   && !I_CPU_IRQ_TAKEN && !I_CPU_SEI;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_IRQ_REQ      <= 1'b0;
      O_IRQ_DISABLED <= 1'b0;
    end else begin
      O_IRQ_REQ      <= nxt_irq;
      O_IRQ_DISABLED <= inhibit_ff || disable_ff;
    end
  end

  // =====================================================
  // vector fetch sequencer
  // =====================================================
  // reset outranks this path simply by holding it idle
  always_comb begin
    case (vec_state_ff)
      ifc_pkg::VEC_IDLE: begin
        nxt_vec_state = I_CPU_IRQ_TAKEN ? ifc_pkg::VEC_LO : ifc_pkg::VEC_IDLE;
      end
      ifc_pkg::VEC_LO: begin
        nxt_vec_state = ifc_pkg::VEC_HI;
      end
      ifc_pkg::VEC_HI: begin
        nxt_vec_state = ifc_pkg::VEC_IDLE;
      end
      default: begin
        nxt_vec_state = ifc_pkg::VEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      vec_state_ff <= ifc_pkg::VEC_IDLE;
    end else begin
      vec_state_ff <= nxt_vec_state;
    end
  end

  // address and strobe registered from the next state
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_VEC_ADDR  <= `IFC_VEC_IDLE;
      O_VEC_FETCH <= 1'b0;
    end else begin
      case (nxt_vec_state)
        ifc_pkg::VEC_LO: begin
          O_VEC_ADDR  <= `IFC_VEC_LO;
          O_VEC_FETCH <= 1'b1;
        end
        ifc_pkg::VEC_HI: begin
          O_VEC_ADDR  <= `IFC_VEC_HI;
          O_VEC_FETCH <= 1'b1;
        end
        default: begin
          O_VEC_ADDR  <= `IFC_VEC_IDLE;
          O_VEC_FETCH <= 1'b0;
        end
      endcase
    end
  end

  // =====================================================
  // checks
  // =====================================================
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  sequence seq_vec_lo;
    O_VEC_FETCH && (O_VEC_ADDR == `IFC_VEC_LO);
  endsequence

  sequence seq_vec_hi;
    O_VEC_FETCH && (O_VEC_ADDR == `IFC_VEC_HI);
  endsequence

  AST_WINDOW_ONLY: assert property (
    (I_SFR_WR && !in_window(I_SFR_ADDR)) |=> $stable(enable_ff))
    else $error("write outside sfr window changed enable");

  AST_VECTOR_SEQ: assert property (
    ((vec_state_ff == ifc_pkg::VEC_IDLE) && I_CPU_IRQ_TAKEN)
    |=> seq_vec_lo ##1 seq_vec_hi ##1 !O_VEC_FETCH)
    else $error("vector bytes not fetched in order");

  AST_REQ_CAUSE: assert property (
    O_IRQ_REQ |-> $past(pending) && !$past(inhibit_ff) && !$past(disable_ff))
    else $error("request without enabled flag");

  AST_REQ_RAISE: assert property (
    (pending && !inhibit_ff && !disable_ff && !I_CPU_IRQ_TAKEN && !I_CPU_SEI)
    |=> O_IRQ_REQ)
    else $error("enabled flag raised no request");

  AST_TAKEN_BLOCKS: assert property (
    (I_CPU_IRQ_TAKEN && !I_CPU_CLI && !wr_enable)
    ##1 (!I_CPU_CLI && !wr_enable) |=> !O_IRQ_REQ)
    else $error("request after taken without release");

  AST_SEI_BLOCKS: assert property (
    I_CPU_SEI |=> !O_IRQ_REQ ##1 (!O_IRQ_REQ || $past(I_CPU_CLI)))
    else $error("request while disabled");

  // enables that miss every live or arriving flag must leave no request pending
  AST_ENABLE_GATES: assert property (
    (wr_enable
     && ((I_SFR_WDATA[`IFC_SRC_NUM-1:0]
          & (status_ff[`IFC_SRC_NUM-1:0] | evt_vec[`IFC_SRC_NUM-1:0])) == 7'h00))
    |=> !pending)
    else $error("cleared enable still passes its flag");

  AST_ENABLE_BIT7: assert property (
    rd_enable |=> O_SFR_RVALID && !O_SFR_RDATA[7]
                  && (O_SFR_RDATA[6:0] == $past(enable_ff)))
    else $error("enable read wrong");

  AST_STATUS_READ: assert property (
    rd_status |=> O_SFR_RVALID && (O_SFR_RDATA == $past(status_ff)))
    else $error("status read wrong");

  AST_CLEAR_ONES: assert property (
    wr_clear |=> ((status_ff & $past(I_SFR_WDATA) & ~$past(evt_vec)) == 8'h00))
    else $error("clear write left flag set");

  AST_STICKY: assert property (
    !wr_clear |=> (status_ff == ($past(status_ff) | $past(evt_vec))))
    else $error("flag changed without clear");

  AST_NO_WRITE_SET: assert property (
    wr_clear |=> ((status_ff & ~$past(status_ff) & ~$past(evt_vec)) == 8'h00))
    else $error("clear write set a flag");

  AST_SET_WINS: assert property (
    wr_clear |=> ((status_ff & $past(evt_vec)) == $past(evt_vec)))
    else $error("event lost under clear");

endmodule // ifc_top

// ===== bench/ifc_cpu_model.sv
// behavioural cpu core model: takes requests and records the vector fetch
`timescale 1ns/1ns

module ifc_cpu_model (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // device side
  input  wire logic        i_irq_req,
  input  wire logic        i_vec_fetch,
  input  wire logic [15:0] i_vec_addr,
  // bench control
  input  wire logic        i_accept_en,
  input  wire logic [3:0]  i_delay,
  // answers and observations
  output logic             o_taken,
  output logic [15:0]      o_vec_lo,
  output logic [15:0]      o_vec_hi,
  output logic [7:0]       o_take_count
);
  // =====================================================
  // request acceptance
  logic [3:0] wait_ff;
  logic       fetch_ff;

  // the request must still stand when the slow path finally takes it
  always @(negedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_taken      <= 1'b0;
      wait_ff      <= 4'h0;
      o_take_count <= 8'h00;
    end else begin
      o_taken <= 1'b0;
      if (!o_taken && i_accept_en && i_irq_req) begin
        if (wait_ff >= i_delay) begin
          o_taken      <= 1'b1;
          wait_ff      <= 4'h0;
          o_take_count <= o_take_count + 8'h01;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end else begin
        wait_ff <= 4'h0;
      end
    end
  end

  // =====================================================
  // vector capture: first fetch cycle is low byte, second is high byte
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fetch_ff <= 1'b0;
      o_vec_lo <= 16'h0000;
      o_vec_hi <= 16'h0000;
    end else begin
      fetch_ff <= i_vec_fetch;
      if (i_vec_fetch && !fetch_ff) o_vec_lo <= i_vec_addr;
      if (i_vec_fetch && fetch_ff) o_vec_hi <= i_vec_addr;
    end
  end
endmodule // ifc_cpu_model

// ===== bench/test_interrupt_flag_controller.sv
// self-checking bench of the interrupt flag controller
`timescale 1ns/1ns
`include "ifc_regs.svh"

module test_interrupt_flag_controller;
  localparam logic [15:0] a_en = {`IFC_PAGE_ZERO, `IFC_OFF_ENABLE};
  localparam logic [15:0] a_st = {`IFC_PAGE_ZERO, `IFC_OFF_STATUS};
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, supply = 1'b0;
  logic cli = 1'b0, sei = 1'b0, taken, req, dis, fetch, rvalid, accept = 1'b0;
  logic [15:0] addr = 16'h0000, vaddr, vlo, vhi;
  logic [7:0]  wdata = 8'h00, rdata, pin = 8'hff, mode = 8'h01, ev = 8'h00, takes;
  logic [3:0]  delay = 4'h0;
  int          err_total = 0, cmp_count = 0, tests = 0, i, d;

  // =====================================================
  // clock and design
  initial forever #2 clk = ~clk;

  ifc_top uut (.I_CLK_SYS(clk), .I_RESETN(resetn), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
    .I_SFR_RD(rd), .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .O_SFR_RVALID(rvalid),
    .I_TIMER_ZERO_UNDERFLOW(ev[3]), .I_TIMER_ONE_UNDERFLOW(ev[5]),
    .I_TIMER_TWO_UNDERFLOW(ev[6]), .I_DIV_TICK(ev[4]), .I_RTC_HALF_SEC_TICK(ev[0]),
    .I_WDT_EVENT(ev[7]), .I_PORT_PIN(pin), .I_PORT_INPUT_MODE(mode),
    .I_SECONDARY_SUPPLY_STATUS(supply), .I_CPU_IRQ_TAKEN(taken), .I_CPU_CLI(cli),
    .I_CPU_SEI(sei), .O_IRQ_REQ(req), .O_IRQ_DISABLED(dis), .O_VEC_ADDR(vaddr),
    .O_VEC_FETCH(fetch));

  ifc_cpu_model cpu (.i_clk_sys(clk), .i_resetn(resetn), .i_irq_req(req),
    .i_vec_fetch(fetch), .i_vec_addr(vaddr), .i_accept_en(accept), .i_delay(delay),
    .o_taken(taken), .o_vec_lo(vlo), .o_vec_hi(vhi), .o_take_count(takes));

  // =====================================================
  // compare, bus and closing tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done;
    $display("tests %0d compares %0d mismatches %0d", tests, cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic endt(input string n);
    tests++;
    $display("test %s done", n);
  endtask

  task automatic wrt(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // a miss must give no valid strobe in the answer cycle
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic hit);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    // valid stands for one cycle only, so look now, not an edge later
    chk("rvalid", {15'h0, hit}, {15'h0, rvalid});
    if (hit) chk("rdata", {8'h0, e}, {8'h0, rdata});
  endtask

  task automatic pulse(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
    @(negedge clk);
  endtask

  task automatic cpu_pulse(input logic s);
    @(negedge clk);
    if (s) sei = 1'b1;
    else cli = 1'b1;
    @(negedge clk);
    sei = 1'b0;
    cli = 1'b0;
    @(negedge clk);
  endtask

  task automatic lines(input logic r, input logic ds);
    repeat (2) @(negedge clk);
    chk("irq_req", {15'h0, r}, {15'h0, req});
    chk("irq_disabled", {15'h0, ds}, {15'h0, dis});
  endtask

  // =====================================================
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    lines(1'b0, 1'b0);
    rdc(a_en, 8'h00, 1'b1);
    rdc(a_st, 8'h00, 1'b1);
    wrt(a_en, 8'hff);
    rdc(a_en, 8'h7f, 1'b1);
    wrt(a_st, 8'hff);
    rdc(a_st, 8'h00, 1'b1);
    rdc(16'h00c4, 8'h00, 1'b0);
    rdc(16'h01c2, 8'h00, 1'b0);
    wrt(16'h01c2, 8'h00);
    rdc(a_en, 8'h7f, 1'b1);
    wrt(a_en, 8'h00);
    endt("registers");

    // every pulse source sets its own bit, with its enable at zero
    foreach (ev[b]) begin
      if (b != 1 && b != 2) begin
        pulse(b);
        chk("req_masked", 16'h0, {15'h0, req});
        rdc(a_st, 8'h01 << b, 1'b1);
        wrt(a_st, ~(8'h01 << b));
        rdc(a_st, 8'h01 << b, 1'b1);
        wrt(a_st, 8'h01 << b);
        rdc(a_st, 8'h00, 1'b1);
      end
    end
    endt("pulse sources");

    pin[1] = 1'b0;
    repeat (3) @(negedge clk);
    rdc(a_st, 8'h00, 1'b1);
    pin[0] = 1'b0;
    repeat (3) @(negedge clk);
    rdc(a_st, 8'h04, 1'b1);
    wrt(a_st, 8'h04);
    pin = 8'hff;
    repeat (3) @(negedge clk);
    rdc(a_st, 8'h00, 1'b1);
    for (i = 0; i < 2; i++) begin
      supply = ~supply;
      repeat (3) @(negedge clk);
      rdc(a_st, 8'h02, 1'b1);
      wrt(a_st, 8'h02);
    end
    endt("level sources");

    // event and clear in one cycle: the event must win
    @(negedge clk);
    ev[3] = 1'b1;
    addr = a_st;
    wdata = 8'h08;
    wr = 1'b1;
    @(negedge clk);
    ev[3] = 1'b0;
    wr = 1'b0;
    rdc(a_st, 8'h08, 1'b1);
    wrt(a_st, 8'h08);
    endt("set over clear");

    // prompt and slow acceptance by the core model
    for (d = 0; d < 2; d++) begin
      delay = d ? 4'h5 : 4'h0;
      wrt(a_en, 8'h08);
      pulse(3);
      lines(1'b1, 1'b0);
      accept = 1'b1;
      for (i = 0; i < 20 && takes == 8'(d); i++) @(negedge clk);
      // a timeout is counted and the run still ends in the closing report
      if (takes == 8'(d)) begin
        chk("take_timeout", 16'h1, 16'h0);
      end
      accept = 1'b0;
      repeat (4) @(negedge clk);
      chk("vec_lo", `IFC_VEC_LO, vlo);
      chk("vec_hi", `IFC_VEC_HI, vhi);
      chk("vec_idle", `IFC_VEC_IDLE, vaddr);
      lines(1'b0, 1'b1);
      wrt(a_en, 8'h08);
      lines(1'b1, 1'b0);
      wrt(a_st, 8'h08);
      lines(1'b0, 1'b0);
    end
    endt("vector fetch");

    pulse(3);
    cpu_pulse(1'b1);
    lines(1'b0, 1'b1);
    cpu_pulse(1'b0);
    lines(1'b1, 1'b0);
    wrt(a_en, 8'h00);
    lines(1'b0, 1'b0);
    wrt(a_st, 8'h08);
    endt("disable and enable");
    test_done();
  end
endmodule // test_interrupt_flag_controller
